// [design/gvs_supervisor.sv]
// Grid voltage and frequency supervisor with APB register slave
//
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - While running, overvoltage warning after voltage exceeds warning limit for delay.
// - Overvoltage warning/fault hold until voltage falls to limit minus voltage hysteresis.
// - Overvoltage delayed fault and stop after same delay above fault limit.
// - Instant overvoltage fault and stop above instant limit, no delay.
// - While running, undervoltage warning after voltage below warning limit for delay.
// - Undervoltage warning/fault hold until voltage rises to limit plus hysteresis.
// - Undervoltage delayed fault and stop after same delay below fault limit.
// - Instant undervoltage fault and stop below instant limit.
// - While running, high-frequency warning after frequency above limit for delay.
// - High-frequency warning/fault hold until frequency falls to limit minus hysteresis.
// - High-frequency delayed fault and stop after same delay above fault limit.
// - Instant high-frequency fault and stop above instant limit.
// - While running, low-frequency warning after frequency below limit for delay.
// - Low-frequency warning/fault hold until frequency rises to limit plus hysteresis.
// - Low-frequency delayed fault and stop after same delay below fault limit.
// - Instant low-frequency fault and stop below instant limit.
module gvs_supervisor
	import gvs_pkg::*;
(
	input  wire logic             core_clk,   // System clock, 50 MHz
	input  wire logic             rst,        // Async reset, active high
	input  wire logic             running,    // Converter is running
	input  wire logic [VAL_W-1:0] voltPct,    // Measured grid voltage
	input  wire logic [VAL_W-1:0] gridFreq,   // Measured grid frequency
	input  wire logic             psel,       // APB select
	input  wire logic             penable,    // APB enable
	input  wire logic             pwrite,     // APB direction
	input  wire logic [7:0]       paddr,      // APB byte address
	input  wire logic [31:0]      pwdata,     // APB write data
	output logic      [31:0]      prdata,     // APB read data
	output logic                  pready,     // APB ready
	output logic                  pslverr,    // APB error
	output logic      [CH_N-1:0]  warnFlag,   // Warning per channel
	output logic      [CH_N-1:0]  faultFlag,  // Delayed fault per channel
	output logic      [CH_N-1:0]  instFlag,   // Instant fault per channel
	output logic                  stopReq     // Stop request
);

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers
	logic             enable_q, enable_d;
	logic [VAL_W-1:0] voltHyst_q, voltHyst_d;
	logic [VAL_W-1:0] freqHyst_q, freqHyst_d;
	logic [VAL_W-1:0] warnLim_q [CH_N];
	logic [VAL_W-1:0] warnLim_d [CH_N];
	logic [VAL_W-1:0] faultLim_q [CH_N];
	logic [VAL_W-1:0] faultLim_d [CH_N];
	logic [VAL_W-1:0] instLim_q [CH_N];
	logic [VAL_W-1:0] instLim_d [CH_N];
	logic [DLY_W-1:0] delay_q [CH_N];
	logic [DLY_W-1:0] delay_d [CH_N];
	logic [31:0]      prdata_d;
	logic             pready_d, pslverr_d;

	logic        active;
	logic        wrEn;
	logic        rdEn;
	logic [31:0] statusWord;
	logic [2:0]  chIdx;
	logic        chHit;

	// Supervision runs only when software enables it and the converter runs
	assign active = enable_q & running;
	assign wrEn = psel & penable & pwrite & ~pready;
	assign rdEn = psel & penable & ~pwrite & ~pready;
	assign chIdx = 3'(((paddr - A_CH_BASE) >> 4));
	assign chHit = (paddr >= A_CH_BASE) && (paddr < A_MEAS_V);

	always_comb begin
		enable_d = enable_q;
		voltHyst_d = voltHyst_q;
		freqHyst_d = freqHyst_q;
		warnLim_d = warnLim_q;
		faultLim_d = faultLim_q;
		instLim_d = instLim_q;
		delay_d = delay_q;
		prdata_d = prdata;
		pslverr_d = 1'b0;
		// Answer one cycle into the access phase, pready a single-cycle pulse
		pready_d = psel & penable & ~pready;
		if (wrEn) begin
			if (paddr == A_CTRL) begin
				enable_d = pwdata[CTRL_EN_BIT];
			end else if (paddr == A_VOLT_HYST) begin
				voltHyst_d = pwdata[VAL_W-1:0];
			end else if (paddr == A_FREQ_HYST) begin
				freqHyst_d = pwdata[VAL_W-1:0];
			end else if (chHit && paddr[1:0] == 2'b00) begin
				unique case (paddr[3:2])
					O_WARN_LIM:  warnLim_d[chIdx[1:0]] = pwdata[VAL_W-1:0];
					O_FAULT_LIM: faultLim_d[chIdx[1:0]] = pwdata[VAL_W-1:0];
					O_INST_LIM:  instLim_d[chIdx[1:0]] = pwdata[VAL_W-1:0];
					O_DELAY:     delay_d[chIdx[1:0]] = pwdata[DLY_W-1:0];
				endcase
			end else if (paddr != A_STATUS && paddr != A_MEAS_V
					&& paddr != A_MEAS_F) begin
				pslverr_d = 1'b1;
			end
		end
		if (rdEn) begin
			prdata_d = 32'h0000_0000;
			if (paddr == A_CTRL) begin
				prdata_d[CTRL_EN_BIT] = enable_q;
			end else if (paddr == A_STATUS) begin
				prdata_d = statusWord;
			end else if (paddr == A_VOLT_HYST) begin
				prdata_d[VAL_W-1:0] = voltHyst_q;
			end else if (paddr == A_FREQ_HYST) begin
				prdata_d[VAL_W-1:0] = freqHyst_q;
			end else if (paddr == A_MEAS_V) begin
				prdata_d[VAL_W-1:0] = voltPct;
			end else if (paddr == A_MEAS_F) begin
				prdata_d[VAL_W-1:0] = gridFreq;
			end else if (chHit && paddr[1:0] == 2'b00) begin
				unique case (paddr[3:2])
					O_WARN_LIM:  prdata_d[VAL_W-1:0] = warnLim_q[chIdx[1:0]];
					O_FAULT_LIM: prdata_d[VAL_W-1:0] = faultLim_q[chIdx[1:0]];
					O_INST_LIM:  prdata_d[VAL_W-1:0] = instLim_q[chIdx[1:0]];
					O_DELAY:     prdata_d[DLY_W-1:0] = delay_q[chIdx[1:0]];
				endcase
			end else begin
				pslverr_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			enable_q <= 1'b1;
			voltHyst_q <= RST_HYST;
			freqHyst_q <= RST_HYST;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			for (int i = 0; i < CH_N; i++) begin
				// Upper channels idle at max, lower ones at zero
				warnLim_q[i] <= (i == CH_OV || i == CH_HF) ? RST_HI : RST_LO;
				faultLim_q[i] <= (i == CH_OV || i == CH_HF) ? RST_HI : RST_LO;
				instLim_q[i] <= (i == CH_OV || i == CH_HF) ? RST_HI : RST_LO;
				delay_q[i] <= RST_DELAY;
			end
		end else begin
			enable_q <= enable_d;
			voltHyst_q <= voltHyst_d;
			freqHyst_q <= freqHyst_d;
			prdata <= prdata_d;
			pready <= pready_d;
			pslverr <= pslverr_d;
			warnLim_q <= warnLim_d;
			faultLim_q <= faultLim_d;
			instLim_q <= instLim_d;
			delay_q <= delay_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Supervision channels
	wire  [CH_N-1:0] warnOut_d, faultOut_d, instOut_d;
	logic            stop_d;

	genvar g;
	generate
		for (g = 0; g < CH_N; g++) begin : gCh
			localparam bit IS_HIGH = (g == CH_OV) || (g == CH_HF);
			logic [VAL_W-1:0] meas, hyst;
			logic [VAL_W:0]   wRel, fRel;
			logic             wTrig, fTrig, iTrig;
			logic             wHold_q, wHold_d, fHold_q, fHold_d;
			logic [DLY_W-1:0] wCnt_q, wCnt_d, fCnt_q, fCnt_d;
			logic             wOn_d, fOn_d;

			assign meas = (g == CH_OV || g == CH_UV) ? voltPct : gridFreq;
			assign hyst = (g == CH_OV || g == CH_UV) ? voltHyst_q : freqHyst_q;
			// Release thresholds in one extra bit so they never wrap
			assign wRel = IS_HIGH
				? {1'b0, warnLim_q[g]} - {1'b0, hyst}
				: {1'b0, warnLim_q[g]} + {1'b0, hyst};
			assign fRel = IS_HIGH
				? {1'b0, faultLim_q[g]} - {1'b0, hyst}
				: {1'b0, faultLim_q[g]} + {1'b0, hyst};

			always_comb begin
				if (IS_HIGH) begin
					wTrig = wHold_q ? ($signed({1'b0, meas}) > $signed(wRel))
						: (meas > warnLim_q[g]);
					fTrig = fHold_q ? ($signed({1'b0, meas}) > $signed(fRel))
						: (meas > faultLim_q[g]);
					iTrig = meas > instLim_q[g];
				end else begin
					wTrig = wHold_q ? ({1'b0, meas} < wRel)
						: (meas < warnLim_q[g]);
					fTrig = fHold_q ? ({1'b0, meas} < fRel)
						: (meas < faultLim_q[g]);
					iTrig = meas < instLim_q[g];
				end
				wHold_d = active & wTrig;
				fHold_d = active & fTrig;
				wCnt_d = (active & wTrig) ? wCnt_q : '0;
				fCnt_d = (active & fTrig) ? fCnt_q : '0;
				wOn_d = active & wTrig & (wCnt_q >= delay_q[g]);
				fOn_d = active & fTrig & (fCnt_q >= delay_q[g]);
				if (active & wTrig & ~wOn_d) begin
					wCnt_d = wCnt_q + 1'b1;
				end
				if (active & fTrig & ~fOn_d) begin
					fCnt_d = fCnt_q + 1'b1;
				end
			end

			// One continuous driver per bit keeps the vectors single-driven
			assign warnOut_d[g] = wOn_d;
			assign faultOut_d[g] = fOn_d;
			assign instOut_d[g] = active & iTrig;

			// Hold tracks when the limit was first crossed, not the timed output
			always_ff @(posedge core_clk or posedge rst) begin
				// cleared at reset and when not running
				if (rst) begin
					wHold_q <= 1'b0;
					fHold_q <= 1'b0;
					wCnt_q <= '0;
					fCnt_q <= '0;
				end else begin
					wHold_q <= wHold_d;
					fHold_q <= fHold_d;
					wCnt_q <= wCnt_d;
					fCnt_q <= fCnt_d;
				end
			end
		end
	endgenerate

	// Stop on any delayed or instant fault
	assign stop_d = |faultOut_d | |instOut_d;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			warnFlag <= '0;
			faultFlag <= '0;
			instFlag <= '0;
			stopReq <= 1'b0;
		end else begin
			warnFlag <= warnOut_d;
			faultFlag <= faultOut_d;
			instFlag <= instOut_d;
			stopReq <= stop_d;
		end
	end

	always_comb begin
		statusWord = 32'h0000_0000;
		statusWord[ST_WARN_LSB +: CH_N] = warnFlag;
		statusWord[ST_FAULT_LSB +: CH_N] = faultFlag;
		statusWord[ST_INST_LSB +: CH_N] = instFlag;
		statusWord[ST_STOP_BIT] = stopReq;
		statusWord[ST_RUN_BIT] = active;
	end

endmodule

`default_nettype wire

// [pkg/gvs_pkg.sv]
// Package of constants for the grid voltage and frequency supervisor
package gvs_pkg;
	localparam int unsigned VAL_W = 16;
	localparam int unsigned DLY_W = 24;
	localparam int unsigned CH_N = 4;
	// Channel indices
	localparam int unsigned CH_OV = 0;
	localparam int unsigned CH_UV = 1;
	localparam int unsigned CH_HF = 2;
	localparam int unsigned CH_LF = 3;
	// Register byte addresses
	localparam logic [7:0] A_CTRL      = 8'h00;
	localparam logic [7:0] A_STATUS    = 8'h04;
	localparam logic [7:0] A_VOLT_HYST = 8'h08;
	localparam logic [7:0] A_FREQ_HYST = 8'h0C;
	localparam logic [7:0] A_CH_BASE   = 8'h10;
	localparam logic [7:0] A_CH_STRIDE = 8'h10;
	localparam logic [1:0] O_WARN_LIM  = 2'h0;
	localparam logic [1:0] O_FAULT_LIM = 2'h1;
	localparam logic [1:0] O_INST_LIM  = 2'h2;
	localparam logic [1:0] O_DELAY     = 2'h3;
	localparam logic [7:0] A_MEAS_V    = 8'h50;
	localparam logic [7:0] A_MEAS_F    = 8'h54;
	// Field positions
	localparam int unsigned CTRL_EN_BIT  = 0;
	localparam int unsigned ST_WARN_LSB  = 0;
	localparam int unsigned ST_FAULT_LSB = 4;
	localparam int unsigned ST_INST_LSB  = 8;
	localparam int unsigned ST_STOP_BIT  = 12;
	localparam int unsigned ST_RUN_BIT   = 13;
	// Reset values
	localparam logic [VAL_W-1:0] RST_HYST  = 16'h0002;
	localparam logic [VAL_W-1:0] RST_HI    = 16'hFFFF;
	localparam logic [VAL_W-1:0] RST_LO    = 16'h0000;
	localparam logic [DLY_W-1:0] RST_DELAY = 24'h00_0032;
endpackage

// [verification/gvs_checker.sv]
// Port-level assertions for the grid supervisor
`timescale 1ns/100ps
`default_nettype none
module gvs_checker
	import gvs_pkg::*;
(
	input wire logic             core_clk,  // Clock
	input wire logic             rst,       // Reset
	input wire logic             running,   // Run state
	input wire logic [VAL_W-1:0] voltPct,   // Voltage
	input wire logic [VAL_W-1:0] gridFreq,  // Frequency
	input wire logic             psel,      // Select
	input wire logic             penable,   // Enable
	input wire logic             pready,    // Ready
	input wire logic [CH_N-1:0]  warnFlag,  // Warnings
	input wire logic [CH_N-1:0]  faultFlag, // Delayed faults
	input wire logic [CH_N-1:0]  instFlag,  // Instant faults
	input wire logic             stopReq    // Stop
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (rst);
	sequence access_s;
		psel && $rose(penable);
	endsequence
	// No input or setting moved, so no instant flag may move
	sequence quiet_s;
		running && $past(running) && !psel && $stable(voltPct)
			&& $stable(gridFreq);
	endsequence
	stop_sum_a: assert property (
		stopReq == (|faultFlag || |instFlag)) else $error("stop mismatch");
	idle_clear_a: assert property (
		!running |=> !warnFlag && !faultFlag && !instFlag)
		else $error("flags kept while idle");
	run_only_a: assert property (
		(warnFlag | faultFlag | instFlag) != 0 |-> $past(running))
		else $error("flag without running");
	inst_hold_a: assert property (
		quiet_s |=> $stable(instFlag)) else $error("instant flag drift");
	stop_idle_a: assert property (
		!running [*2] |-> !stopReq) else $error("stop while idle");
	warn_fall_a: assert property (
		$fell(warnFlag[CH_OV]) |-> $past(!running) || $past(psel)
		|| $past(voltPct) != $past(voltPct, 2)) else $error("warn fell");
	ready_wait_a: assert property (
		access_s |=> pready) else $error("ready late");
	ready_pulse_a: assert property (
		pready |=> !pready) else $error("ready too long");
endmodule
bind gvs_supervisor gvs_checker chk_i(.core_clk(core_clk), .rst(rst),
	.running(running), .voltPct(voltPct), .gridFreq(gridFreq),
	.psel(psel), .penable(penable), .pready(pready),
	.warnFlag(warnFlag), .faultFlag(faultFlag), .instFlag(instFlag),
	.stopReq(stopReq));
`default_nettype wire

// [verification/gvs_meas_model.sv]
// Measurement path model feeding voltage and frequency samples
`timescale 1ns/100ps
`default_nettype none
module gvs_meas_model
	import gvs_pkg::*;
(
	input  wire logic             core_clk, // Clock
	input  wire logic [VAL_W-1:0] vTgt,     // Voltage to report
	input  wire logic [VAL_W-1:0] fTgt,     // Frequency to report
	output logic      [VAL_W-1:0] voltPct,  // Voltage sample
	output logic      [VAL_W-1:0] gridFreq  // Frequency sample
);
	// One sample of latency, as a real filter stage would add
	always_ff @(posedge core_clk) begin
		voltPct <= vTgt;
		gridFreq <= fTgt;
	end
endmodule
`default_nettype wire

// [verification/gvs_supervisor_tb.sv]
// Self-checking bench for the grid supervisor
`timescale 1ns/100ps
`default_nettype none
module gvs_supervisor_tb import gvs_pkg::*;;
	logic             core_clk, rst, running, psel, penable, pwrite;
	logic             pready, pslverr, stopReq, er;
	logic [7:0]       paddr;
	logic [31:0]      pwdata, prdata, rd;
	logic [VAL_W-1:0] voltPct, gridFreq, vTgt, fTgt;
	logic [CH_N-1:0]  warnFlag, faultFlag, instFlag;
	wire logic [11:0] flags = {instFlag, faultFlag, warnFlag};
	int               fails, n_compared, n, hy;
	int               dly[4];
	gvs_supervisor uut(.core_clk(core_clk), .rst(rst), .running(running),
		.voltPct(voltPct), .gridFreq(gridFreq), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.warnFlag(warnFlag), .faultFlag(faultFlag), .instFlag(instFlag),
		.stopReq(stopReq));
	gvs_meas_model meas(.core_clk(core_clk), .vTgt(vTgt), .fTgt(fTgt),
		.voltPct(voltPct), .gridFreq(gridFreq));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	task automatic wrap_up();
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input int d);
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= 32'(d);
		@(posedge core_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	function automatic logic [7:0] ca(input int c, input int o);
		return A_CH_BASE + 8'(c) * A_CH_STRIDE + 8'(4 * o);
	endfunction
	// Upper channels are even; offsets move away from the 500 limit
	function automatic int tv(input int c, input int off);
		return (c % 2 == 0) ? 500 + off : 500 - off;
	endfunction
	// Model adds one edge, the design's registered flag output one more
	function automatic int lat(input int d);
		return d + 2;
	endfunction
	// Status word with every event of one channel up, converter running
	function automatic logic [31:0] st(input int c);
		return (32'h0000_0001 << (ST_WARN_LSB + c))
			| (32'h0000_0001 << (ST_FAULT_LSB + c))
			| (32'h0000_0001 << (ST_INST_LSB + c))
			| (32'h0000_0001 << ST_STOP_BIT)
			| (32'h0000_0001 << ST_RUN_BIT);
	endfunction
	task automatic put(input int c, input int off);
		@(posedge core_clk);
		if (c < 2)
			vTgt <= 16'(tv(c, off));
		else
			fTgt <= 16'(tv(c, off));
	endtask
	task automatic cnt(input int c, input int kind);
		n = 0;
		do begin
			@(posedge core_clk);
			#1;
			n++;
		end while (flags[kind * 4 + c] !== 1'b1 && n < 300);
	endtask
	task automatic settle(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	initial begin
		rst = 1'b1;
		{running, psel, penable, pwrite, paddr, pwdata} = '0;
		vTgt = 16'h01F4;
		fTgt = 16'h01F4;
		void'($urandom(32'he202_e61c));
		repeat (4) @(posedge core_clk);
		rst <= 1'b0;
		apb(0, A_VOLT_HYST, 0);
		chk(rd, 32'h0000_0002);
		apb(0, ca(CH_OV, 3), 0);
		chk(rd, 32'h0000_0032);
		apb(0, 8'h60, 0);
		chk(er, 1'b1);
		hy = 2 + $urandom % 3;
		apb(1, A_VOLT_HYST, hy);
		apb(1, A_FREQ_HYST, hy);
		for (int c = 0; c < 4; c++) begin
			dly[c] = 1 + $urandom % 6;
			apb(1, ca(c, 0), tv(c, 0));
			apb(1, ca(c, 1), tv(c, 20));
			apb(1, ca(c, 2), tv(c, 100));
			apb(1, ca(c, 3), dly[c]);
		end
		running <= 1'b1;
		for (int c = 0; c < 4; c++) begin
			put(c, 10 + $urandom % 9);
			cnt(c, 0);
			chk(n, lat(dly[c]));
			chk(flags[4 + c], 1'b0);
			put(c, 1 - hy);
			settle(4);
			chk(flags[c], 1'b1);
			put(c, -hy);
			settle(4);
			chk(flags[c], 1'b0);
			put(c, 30);
			repeat (dly[c] - 1) @(posedge core_clk);
			put(c, -5);
			repeat (3) @(posedge core_clk);
			put(c, 30);
			cnt(c, 1);
			chk(n, lat(dly[c]));
			chk(stopReq, 1'b1);
			put(c, 110);
			cnt(c, 2);
			chk(n, 2);
			apb(0, A_STATUS, 0);
			chk(rd, st(c));
			running <= 1'b0;
			settle(2);
			chk({stopReq, flags}, 13'h0000);
			put(c, 0);
			@(posedge core_clk);
			running <= 1'b1;
		end
		// Software disable acts like a stopped converter
		put(CH_OV, 110);
		settle(4);
		chk(instFlag[CH_OV], 1'b1);
		apb(1, A_CTRL, 0);
		settle(2);
		chk({stopReq, flags}, 13'h0000);
		apb(0, A_STATUS, 0);
		chk(rd, 32'h0000_0000);
		// Mid-run reset clears outputs and restores the configuration
		@(posedge core_clk);
		rst <= 1'b1;
		settle(2);
		chk({pready, stopReq, flags}, 14'h0000);
		@(posedge core_clk);
		rst <= 1'b0;
		apb(0, A_CTRL, 0);
		chk(rd, 32'h0000_0001);
		apb(0, ca(CH_HF, 2), 0);
		chk(rd, 32'h0000_FFFF);
		apb(0, ca(CH_LF, 3), 0);
		chk(rd, 32'h0000_0032);
		apb(0, A_MEAS_V, 0);
		chk(rd, 32'(tv(CH_OV, 110)));
		wrap_up();
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		wrap_up();
	end
endmodule
`default_nettype wire
